// ### tb/sipo_ctl.sv
`timescale 1ns/1ps
module sipo_ctl (
  input wire logic sys_clk, // system clock
  output logic serial_in, // serial data
  output logic shift_clock, // 800 ns, still between bytes
  output logic storage_clock // storage clock, idle low
);
  initial begin
    serial_in = 1'b0;
    shift_clock = 1'b0;
    storage_clock = 1'b0;
  end
  // msb first, data steady 4 cycles round each rise
  task automatic send(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      serial_in <= d[i];
      repeat (4) @(posedge sys_clk);
      shift_clock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      shift_clock <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic latch();
    storage_clock <= 1'b1;
    repeat (4) @(posedge sys_clk);
    storage_clock <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // sipo_ctl

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, rst_b = 0, shift_clear_n = 1, out_enable_n = 0;
  logic serial_in, shift_clock, storage_clock, cascade_serial_out;
  logic [7:0] parallel_outputs, parallel_oe;
  int bad_count = 0, n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  sipo_ctl u_ctl (.sys_clk(sys_clk), .serial_in(serial_in), .shift_clock(shift_clock),
    .storage_clock(storage_clock));
  sipo_latch u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .serial_in(serial_in),
    .shift_clock(shift_clock), .storage_clock(storage_clock), .shift_clear_n(shift_clear_n),
    .out_enable_n(out_enable_n), .parallel_outputs(parallel_outputs),
    .parallel_oe(parallel_oe), .cascade_serial_out(cascade_serial_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // shift holds outputs until latched
  task automatic t_store();
    u_ctl.send(8'ha5);
    check(parallel_outputs, 8'h00);
    check({7'h00, cascade_serial_out}, 8'h01);
    u_ctl.latch();
    check(parallel_outputs, 8'ha5);
    u_ctl.send(8'hc3);
    check(parallel_outputs, 8'ha5);
    check({7'h00, cascade_serial_out}, 8'h01);
    $display("store done");
  endtask
  // output enable both ways
  task automatic t_enable();
    check(parallel_oe, 8'hff);
    out_enable_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(parallel_oe, 8'h00);
    check({7'h00, cascade_serial_out}, 8'h01);
    out_enable_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    $display("enable done");
  endtask
  // clear beats shifting, spares storage
  task automatic t_clear();
    shift_clear_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({7'h00, cascade_serial_out}, 8'h00);
    u_ctl.send(8'hff);
    check({7'h00, cascade_serial_out}, 8'h00);
    check(parallel_outputs, 8'ha5);
    u_ctl.latch();
    check(parallel_outputs, 8'h00);
    shift_clear_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_ctl.latch();
    check(parallel_outputs, 8'h00);
    $display("clear done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(parallel_outputs, 8'h00);
    t_store();
    t_enable();
    t_clear();
    print_verdict();
  end
  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end
endmodule // tb_top

// ### verilog/sipo_latch.sv
`timescale 1ns/1ps
module sipo_latch
  import sipo_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic serial_in, // serial data pin
  input wire logic shift_clock, // shift clock pin
  input wire logic storage_clock, // storage clock pin
  input wire logic shift_clear_n, // shift clear pin, active low
  input wire logic out_enable_n, // output enable pin, active low
  output logic [7:0] parallel_outputs, // parallel data value
  output logic [7:0] parallel_oe, // output enables, high drives
  output logic cascade_serial_out // last stage for chaining
);
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] store_reg;
  logic [7:0] store_next;
  logic si_sync;
  logic clr_n_sync;
  logic oe_n_sync;
  logic shift_rise;
  logic store_rise;
  logic [SIPO_SYNC_STAGES:0] settle_reg;
  logic hist_ok;

  // synchronise every pin; clocks also give edge pulses
  sipo_sync_edge u_sck (
    .sys_clk(sys_clk), // system clock
    .rst_b(rst_b), // reset
    .pin_in(shift_clock), // shift clock pin
    .level_out(), // level not needed
    .rise_pulse(shift_rise) // shift edge pulse
  );

  sipo_sync_edge u_rck (
    .sys_clk(sys_clk), // system clock
    .rst_b(rst_b), // reset
    .pin_in(storage_clock), // storage clock pin
    .level_out(), // level not needed
    .rise_pulse(store_rise) // store edge pulse
  );

  sipo_sync_edge u_si (
    .sys_clk(sys_clk), // system clock
    .rst_b(rst_b), // reset
    .pin_in(serial_in), // serial data pin
    .level_out(si_sync), // synchronised data
    .rise_pulse() // edge not needed
  );

  sipo_sync_edge u_clr (
    .sys_clk(sys_clk), // system clock
    .rst_b(rst_b), // reset
    .pin_in(shift_clear_n), // clear pin
    .level_out(clr_n_sync), // synchronised clear
    .rise_pulse() // edge not needed
  );

  sipo_sync_edge u_oe (
    .sys_clk(sys_clk), // system clock
    .rst_b(rst_b), // reset
    .pin_in(out_enable_n), // enable pin
    .level_out(oe_n_sync), // synchronised enable
    .rise_pulse() // edge not needed
  );

  // shift next value: clear dominates, else shift on edge, else hold
  assign shift_next = !clr_n_sync ? SIPO_SHIFT_RESET : // [R5]
                      shift_rise ? {shift_reg[6:0], si_sync} : // [R2] [R3]
                      shift_reg; // [R4]

  // storage next value: capture on its own edge only, clear ignored
  assign store_next = store_rise ? shift_reg : store_reg; // [R6] [R7] [R8] [R11]

  // register update
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shift_reg <= SIPO_SHIFT_RESET;
      store_reg <= SIPO_STORE_RESET;
    end else begin
      shift_reg <= shift_next;
      store_reg <= store_next; // [R1]
    end
  end

  // pin history is trusted only once every synchroniser stage holds post-reset samples
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      settle_reg <= {(SIPO_SYNC_STAGES + 1){1'b0}};
    end else begin
      settle_reg <= {settle_reg[SIPO_SYNC_STAGES-1:0], 1'b1};
    end
  end

  // pin-level assertions wait for this
  assign hist_ok = settle_reg[SIPO_SYNC_STAGES];

  // outputs: storage drives parallel pins, cascade is last stage
  assign parallel_outputs = store_reg; // [R1]
  assign parallel_oe = {SIPO_WIDTH{~oe_n_sync}}; // [R9]
  assign cascade_serial_out = shift_reg[7]; // [R10]

  // assertions
  chk_clear_zeroes_shift: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
    !clr_n_sync |=> shift_reg == 8'h00)
    else $error("shift register not cleared");
  chk_shift_moves_data: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    (clr_n_sync && shift_rise) |=> shift_reg == {$past(shift_reg[6:0]), $past(si_sync)})
    else $error("shift step wrong");
  chk_shift_holds_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
    (clr_n_sync && !shift_rise) |=> $stable(shift_reg))
    else $error("shift register changed without edge");
  chk_edge_single_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R2]
    shift_rise |=> !shift_rise)
    else $error("shift edge longer than one cycle");
  chk_store_captures: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
    store_rise |=> parallel_outputs == $past(shift_reg))
    else $error("storage did not capture");
  chk_store_holds_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    !store_rise |=> $stable(parallel_outputs))
    else $error("storage changed without edge");
  chk_clear_spares_store: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (!clr_n_sync && !store_rise) |=> $stable(store_reg))
    else $error("clear disturbed storage");
  chk_shift_keeps_store: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R8]
    (shift_rise && !store_rise) |=> $stable(parallel_outputs))
    else $error("shifting disturbed outputs");
  chk_enable_drives: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
    parallel_oe == (oe_n_sync ? 8'h00 : 8'hff))
    else $error("output enable wrong");
  chk_cascade_last: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    (clr_n_sync && shift_rise) |=> cascade_serial_out == $past(shift_reg[6]))
    else $error("cascade not last stage");

  // shift pulse appears only for a low-to-high step of the pin
  chk_shift_edge_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R2]
    hist_ok
    |-> shift_rise == ($past(shift_clock, 2) && !$past(shift_clock, 3)))
    else $error("shift pulse not from a pin rise");

  // a falling shift clock leaves the shift register alone
  chk_fall_no_shift: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R2]
    (hist_ok && $past(shift_clear_n, 2) && !$past(shift_clock, 2) && $past(shift_clock, 3))
    |=> $stable(shift_reg))
    else $error("shift register moved on a falling edge");

  // new stage zero comes from the serial pin as seen at the clock rise
  chk_shift_data_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    (hist_ok && $past(shift_clear_n, 2) && $past(shift_clock, 2) && !$past(shift_clock, 3))
    |=> shift_reg == {$past(shift_reg[6:0]), $past(serial_in, 3)})
    else $error("shift step does not match pins");

  // serial data moving without a clock rise changes nothing
  chk_serial_idle_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
    (clr_n_sync && !shift_rise && $changed(si_sync))
    |=> $stable(shift_reg))
    else $error("serial change moved shift register");

  // a low clear pin empties the shift register
  chk_clear_from_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
    (hist_ok && !$past(shift_clear_n, 2))
    |=> shift_reg == SIPO_SHIFT_RESET)
    else $error("clear pin did not empty shift register");

  // clear wins over a shift pulse in the same cycle
  chk_clear_beats_edge: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
    (!clr_n_sync && shift_rise)
    |=> shift_reg == SIPO_SHIFT_RESET)
    else $error("shift pulse beat the clear");

  // store pulse appears only for a low-to-high step of its pin
  chk_store_edge_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
    hist_ok
    |-> store_rise == ($past(storage_clock, 2) && !$past(storage_clock, 3)))
    else $error("store pulse not from a pin rise");

  // a falling storage clock leaves the outputs alone
  chk_store_fall_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    (hist_ok && !$past(storage_clock, 2) && $past(storage_clock, 3))
    |=> $stable(parallel_outputs))
    else $error("outputs moved on a falling storage edge");

  // the output enable never touches the stored value
  chk_oe_keeps_data: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
    ($changed(oe_n_sync) && !store_rise)
    |=> $stable(parallel_outputs))
    else $error("enable change disturbed outputs");

  // per-bit enables follow the enable pin two cycles late
  chk_enable_from_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
    hist_ok
    |-> parallel_oe == ($past(out_enable_n, 2) ? 8'h00 : 8'hff))
    else $error("enables do not follow pin");

  // cascade keeps its value while only the enable moves
  chk_cascade_ignores_oe: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    ($changed(oe_n_sync) && clr_n_sync && !shift_rise)
    |=> $stable(cascade_serial_out))
    else $error("enable change disturbed cascade");

  // cascade goes low with a clear
  chk_cascade_cleared: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    !clr_n_sync
    |=> !cascade_serial_out)
    else $error("cascade not cleared");

  // a low clear pin leaves the stored word in place
  chk_clear_keeps_pins: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (hist_ok && !$past(shift_clear_n, 2) && !store_rise)
    |=> $stable(parallel_outputs))
    else $error("clear pin disturbed outputs");

  // a store after a clear shows the cleared word
  chk_clear_then_store: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (store_rise && !$past(clr_n_sync))
    |=> parallel_outputs == SIPO_SHIFT_RESET)
    else $error("cleared word not stored");

  // clear edges alone never reach the storage register
  chk_clear_edge_store: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    ($changed(clr_n_sync) && !store_rise)
    |=> $stable(store_reg))
    else $error("clear edge reached storage");
endmodule // sipo_latch

// ### verilog/sipo_pkg.sv
// Function
// R1: eight-stage shift feeds eight-bit storage register
// R2: shift advances only on shift-clock rise
// R3: first stage takes serial input, others shift
// R4: no shift edge, shift contents hold
// R5: clear low forces shift register zero
// R6: storage-clock rise captures whole shift register
// R7: no storage edge, storage value holds
// R8: shift and storage clocks act independently
// R9: enable high floats outputs, low drives
// R10: cascade output always shows last stage
// R11: clear leaves storage register untouched
package sipo_pkg;
  localparam int SIPO_WIDTH = 8;
  localparam logic [7:0] SIPO_SHIFT_RESET = 8'h00;
  localparam logic [7:0] SIPO_STORE_RESET = 8'h00;
  localparam int SIPO_SYNC_STAGES = 2;
endpackage

// ### verilog/sipo_sync_edge.sv
`timescale 1ns/1ps
module sipo_sync_edge
  import sipo_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic pin_in, // asynchronous pin
  output logic level_out, // synchronised level
  output logic rise_pulse // one-cycle pulse on rising edge
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // two-stage synchroniser plus edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // edge found on synchronised copies only
  assign level_out = sync_reg;
  assign rise_pulse = sync_reg & ~prev_reg;
endmodule // sipo_sync_edge
